// file: src/clk_rate_pkg.sv
// Purpose: constants for the master clock rate selection block
// Assumes: pclk at 20 MHz, APB register access with 32-bit data
// Notes: register indices times four give the byte address
package clk_rate_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam longint PCLK_HZ = 20000000;
   localparam int PCLK_PERIOD_NS = 50;
   localparam int REF_WINDOW_NS = 204800;
   localparam int REF_WINDOW_CYC = (REF_WINDOW_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
   localparam int ACC_W = 24;
   localparam int ADDR_W = 16;
   // ----------------------------------------
   // register map (indices)
   // ----------------------------------------
   localparam logic [13:0] IDX_OUT_RATE = 14'h0FF8;
   localparam logic [13:0] IDX_REF_RATE = 14'h0FF9;
   localparam logic [13:0] IDX_REF_STAT = 14'h0FFA;
   localparam logic [7:0] OUT_RATE_RESET = 8'h00;
   localparam logic [7:0] REF_RATE_RESET = 8'h0C;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int T1_SEL_LSB = 6;
   localparam int E1_SEL_LSB = 4;
   localparam int REF_SEL_LSB = 0;
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_COUNT_LSB = 16;
   localparam int STAT_COUNT_W = 16;
   // ----------------------------------------
   // rate tables in Hz
   // ----------------------------------------
   function automatic longint t1_hz(input logic [1:0] sel);
      case (sel)
         2'h0: t1_hz = 1544000;
         2'h1: t1_hz = 3088000;
         2'h2: t1_hz = 6176000;
         default: t1_hz = 12352000;
      endcase
   endfunction : t1_hz
   function automatic longint e1_hz(input logic [1:0] sel);
      case (sel)
         2'h0: e1_hz = 2048000;
         2'h1: e1_hz = 4096000;
         2'h2: e1_hz = 8192000;
         default: e1_hz = 16384000;
      endcase
   endfunction : e1_hz
   function automatic longint ref_hz(input logic [3:0] sel);
      case (sel)
         4'h0: ref_hz = 2048000;
         4'h1: ref_hz = 1544000;
         4'h2: ref_hz = 8000;
         4'h3: ref_hz = 16000;
         4'h4: ref_hz = 56000;
         4'h5: ref_hz = 64000;
         4'h6: ref_hz = 128000;
         4'h7: ref_hz = 256000;
         4'h8: ref_hz = 4096000;
         4'h9: ref_hz = 3088000;
         4'hA: ref_hz = 8192000;
         4'hB: ref_hz = 6176000;
         4'hC: ref_hz = 16384000;
         4'hD: ref_hz = 12352000;
         4'hE: ref_hz = 2048000;
         default: ref_hz = 1544000;
      endcase
   endfunction : ref_hz
   // phase step of an accumulator ticking at pclk
   function automatic logic [23:0] hz_to_step(input longint hz);
      longint s;
      s = (hz * (longint'(1) << ACC_W) + PCLK_HZ / 2) / PCLK_HZ;
      hz_to_step = s[23:0];
   endfunction : hz_to_step
   // edges expected in one window, for a reference of the given rate
   function automatic logic [15:0] hz_to_edges(input longint hz);
      longint e;
      e = (hz * REF_WINDOW_NS) / 64'd1000000000;
      hz_to_edges = (e > 64'd65535) ? 16'hFFFF : e[15:0];
   endfunction : hz_to_edges
endpackage : clk_rate_pkg

// file: src/master_clock_rate_select.sv
// Purpose: programmable output rate clocks and reference rate selection
// Assumes: APB slave, zero wait states, one clock pclk
// Notes: output clocks are synthesised by phase accumulators on pclk
//
// Notes on behaviour
// RULE_01: the t1 output runs at 1.544, 3.088, 6.176 or 12.352 MHz for codes 00 to 11; the code gives 7.648 MHz for code 11, aliased at pclk.
// RULE_02: the e1 output runs at 2.048, 4.096, 8.192 or 16.384 MHz for codes 00 to 11; the code gives 3.616 MHz for code 11, aliased at pclk.
// RULE_03: reference codes 0000 to 0111 mean 2.048M, 1.544M, 8k, 16k, 56k, 64k, 128k and 256k.
// RULE_04: reference codes 1000 to 1111 mean 4.096M, 3.088M, 8.192M, 6.176M, 16.384M, 12.352M, 2.048M, 1.544M.
// RULE_05: the board supplies a reference at the programmed rate before operation is expected.
// RULE_06: both outputs follow the reference and change rate on rewrite without reset; the code runs both from pclk, stopped while no reference edges come.
`timescale 1ns/100ps
module master_clock_rate_select (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic master_ref_clock_in,
   output logic t1_rate_clock_out,
   output logic e1_rate_clock_out,
   output logic ref_rate_ok
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] out_rate_ff, nxt_out_rate;
   logic [7:0] ref_rate_ff, nxt_ref_rate;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;
   logic [2:0] ref_sync_ff;
   logic ref_lvl_ff, nxt_ref_lvl;
   logic [15:0] win_cnt_ff, nxt_win_cnt;
   logic [15:0] edge_cnt_ff, nxt_edge_cnt;
   logic [15:0] edge_last_ff, nxt_edge_last;
   logic active_ff, nxt_active;
   logic ok_ff, nxt_ok;
   logic [23:0] t1_acc_ff, nxt_t1_acc;
   logic [23:0] e1_acc_ff, nxt_e1_acc;
   logic t1_out_ff, nxt_t1_out;
   logic e1_out_ff, nxt_e1_out;
   logic [1:0] t1_sel, e1_sel;
   logic [3:0] ref_sel;
   logic [13:0] idx;
   logic access, hit;
   logic ref_rise;
   logic [15:0] exp_edges;

   assign t1_sel = out_rate_ff[clk_rate_pkg::T1_SEL_LSB +: 2];
   assign e1_sel = out_rate_ff[clk_rate_pkg::E1_SEL_LSB +: 2];
   assign ref_sel = ref_rate_ff[clk_rate_pkg::REF_SEL_LSB +: 4];
   assign idx = paddr[15:2];
   assign access = psel & penable & pready_ff;

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   always_comb begin
      nxt_out_rate = out_rate_ff;
      nxt_ref_rate = ref_rate_ff;
      nxt_prdata = prdata_ff;
      nxt_pslverr = pslverr_ff;
      nxt_pready = psel & ~penable;
      hit = (paddr[1:0] == 2'h0) &&
         (idx == clk_rate_pkg::IDX_OUT_RATE || idx == clk_rate_pkg::IDX_REF_RATE ||
          idx == clk_rate_pkg::IDX_REF_STAT);
      if (psel & ~penable) begin
         nxt_pslverr = ~hit;
         nxt_prdata = 32'h0000_0000;
         if (!pwrite) begin
            case (idx)
               clk_rate_pkg::IDX_OUT_RATE: nxt_prdata = {24'h00_0000, out_rate_ff};
               clk_rate_pkg::IDX_REF_RATE: nxt_prdata = {24'h00_0000, ref_rate_ff};
               clk_rate_pkg::IDX_REF_STAT: begin
                  nxt_prdata[clk_rate_pkg::STAT_COUNT_LSB +: clk_rate_pkg::STAT_COUNT_W] = edge_last_ff;
                  nxt_prdata[clk_rate_pkg::STAT_ACTIVE_BIT] = ok_ff;
               end
               default: nxt_prdata = 32'h0000_0000;
            endcase
         end
      end
      if (access & pwrite & ~pslverr_ff) begin
         // a rewrite takes effect at once, no reset needed [RULE_06]
         if (idx == clk_rate_pkg::IDX_OUT_RATE) begin
            nxt_out_rate = pwdata[7:0];
         end
         if (idx == clk_rate_pkg::IDX_REF_RATE) begin
            nxt_ref_rate = pwdata[7:0];
         end
      end
   end

   // ----------------------------------------
   // reference input sampling and monitor
   // ----------------------------------------
   always_comb begin
      // expected edges per window from the programmed reference code [RULE_03] [RULE_04]
      exp_edges = clk_rate_pkg::hz_to_edges(clk_rate_pkg::ref_hz(ref_sel));
      nxt_ref_lvl = (ref_sync_ff[1] == ref_sync_ff[2]) ? ref_sync_ff[2] : ref_lvl_ff;
      ref_rise = nxt_ref_lvl & ~ref_lvl_ff;
      nxt_edge_cnt = edge_cnt_ff;
      nxt_edge_last = edge_last_ff;
      nxt_active = active_ff;
      nxt_ok = ok_ff;
      if (win_cnt_ff == 16'(clk_rate_pkg::REF_WINDOW_CYC - 1)) begin
         nxt_win_cnt = 16'h0000;
         nxt_edge_last = edge_cnt_ff;
         nxt_edge_cnt = {15'h0000, ref_rise};
         nxt_active = (edge_cnt_ff != 16'h0000);
         // board reference must match the programmed rate [RULE_05]
         nxt_ok = (edge_cnt_ff != 16'h0000) &&
            (edge_cnt_ff + 16'h0001 >= exp_edges) && (edge_cnt_ff <= exp_edges + 16'h0001);
      end else begin
         nxt_win_cnt = win_cnt_ff + 16'h0001;
         if (ref_rise && edge_cnt_ff != 16'hFFFF) begin
            nxt_edge_cnt = edge_cnt_ff + 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // output clock synthesis
   // ----------------------------------------
   always_comb begin
      // outputs run only while the reference is present [RULE_06]
      if (active_ff) begin
         nxt_t1_acc = t1_acc_ff + clk_rate_pkg::hz_to_step(clk_rate_pkg::t1_hz(t1_sel)); // [RULE_01]
         nxt_e1_acc = e1_acc_ff + clk_rate_pkg::hz_to_step(clk_rate_pkg::e1_hz(e1_sel)); // [RULE_02]
      end else begin
         nxt_t1_acc = 24'h00_0000;
         nxt_e1_acc = 24'h00_0000;
      end
      nxt_t1_out = t1_acc_ff[23];
      nxt_e1_out = e1_acc_ff[23];
   end

   // ----------------------------------------
   // state registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_rate_ff <= clk_rate_pkg::OUT_RATE_RESET;
         ref_rate_ff <= clk_rate_pkg::REF_RATE_RESET;
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         ref_sync_ff <= 3'h0;
         ref_lvl_ff <= 1'b0;
         win_cnt_ff <= 16'h0000;
         edge_cnt_ff <= 16'h0000;
         edge_last_ff <= 16'h0000;
         active_ff <= 1'b0;
         ok_ff <= 1'b0;
         t1_acc_ff <= 24'h00_0000;
         e1_acc_ff <= 24'h00_0000;
         t1_out_ff <= 1'b0;
         e1_out_ff <= 1'b0;
      end else begin
         out_rate_ff <= nxt_out_rate;
         ref_rate_ff <= nxt_ref_rate;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         ref_sync_ff <= {ref_sync_ff[1:0], master_ref_clock_in};
         ref_lvl_ff <= nxt_ref_lvl;
         win_cnt_ff <= nxt_win_cnt;
         edge_cnt_ff <= nxt_edge_cnt;
         edge_last_ff <= nxt_edge_last;
         active_ff <= nxt_active;
         ok_ff <= nxt_ok;
         t1_acc_ff <= nxt_t1_acc;
         e1_acc_ff <= nxt_e1_acc;
         t1_out_ff <= nxt_t1_out;
         e1_out_ff <= nxt_e1_out;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign t1_rate_clock_out = t1_out_ff;
   assign e1_rate_clock_out = e1_out_ff;
   assign ref_rate_ok = ok_ff;
endmodule : master_clock_rate_select

// file: sim/clk_rate_sva.sv
// Purpose: port checker for master_clock_rate_select
// Assumes: outputs registered on pclk, zero wait APB slave
// Notes: bound from the bench top file
`timescale 1ns/100ps
module clk_rate_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic t1_rate_clock_out,
   input wire logic e1_rate_clock_out,
   input wire logic ref_rate_ok
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   property p_ready;
      s_setup |=> pready;
   endproperty
   property p_single;
      pready |=> !pready;
   endproperty
   property p_t1_hi;
      $rose(t1_rate_clock_out) && ref_rate_ok |-> ##[1:7] !t1_rate_clock_out;
   endproperty
   property p_t1_lo;
      $fell(t1_rate_clock_out) && ref_rate_ok |-> ##[1:7] t1_rate_clock_out;
   endproperty
   property p_e1_hi;
      $rose(e1_rate_clock_out) && ref_rate_ok |-> ##[1:5] !e1_rate_clock_out;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready in access cycle");
   a_single: assert property (p_single) else $error("ready held too long");
   a_t1_hi: assert property (p_t1_hi) else $error("t1 clock high too long");
   a_t1_lo: assert property (p_t1_lo) else $error("t1 clock low too long");
   a_e1_hi: assert property (p_e1_hi) else $error("e1 clock high too long");
endmodule : clk_rate_sva

// file: sim/ref_osc.sv
// Purpose: board reference oscillator model
// Assumes: rate set by the bench as a half period in ns
// Notes: runs free, as a crystal oscillator does
`timescale 1ns/100ps
module ref_osc (
   input var real half_ns,
   output logic clk_out
);
   initial clk_out = 1'b0;
   // reference at the rate the bench programs
   always begin
      #(half_ns);
      clk_out = ~clk_out;
   end
endmodule : ref_osc

// file: sim/master_clock_rate_select_bench.sv
// Purpose: self-checking bench for master_clock_rate_select
// Assumes: pclk 20 MHz, byte address is index times four
// Notes: rates above 10 MHz alias at the pclk accumulator
`timescale 1ns/100ps
module master_clock_rate_select_bench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic pready, pslverr, ref_clk, t1_rate_clock_out, e1_rate_clock_out, ref_rate_ok;
   real half_ns = 1953.125;
   int err_total = 0, checks = 0, t1_n = 0, e1_n = 0;
   longint hz[16] = '{2048000, 1544000, 8000, 16000, 56000, 64000, 128000, 256000, 4096000, 3088000,
      8192000, 6176000, 16384000, 12352000, 2048000, 1544000};
   longint t1f[4] = '{1544000, 3088000, 6176000, 12352000};
   longint e1f[4] = '{2048000, 4096000, 8192000, 16384000};
   localparam logic [15:0] A_OUT = {clk_rate_pkg::IDX_OUT_RATE, 2'b00};
   localparam logic [15:0] A_REF = {clk_rate_pkg::IDX_REF_RATE, 2'b00};
   localparam logic [15:0] A_STAT = {clk_rate_pkg::IDX_REF_STAT, 2'b00};
   always #25 pclk = ~pclk;
   always @(posedge t1_rate_clock_out) t1_n++;
   always @(posedge e1_rate_clock_out) e1_n++;
   ref_osc osc (.half_ns(half_ns), .clk_out(ref_clk));
   master_clock_rate_select DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .master_ref_clock_in(ref_clk), .t1_rate_clock_out(t1_rate_clock_out),
      .e1_rate_clock_out(e1_rate_clock_out), .ref_rate_ok(ref_rate_ok));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task automatic near(input string n, input longint exp, input longint got, input int tol);
      checks++;
      if (got < exp - tol || got > exp + tol) begin
         err_total++;
         $display("wrong value %s expected %0d seen %0d", n, exp, got);
      end
   endtask : near
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // wait for the slave's answer, only the watchdog ends a hang
      do begin @(posedge pclk); end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb
   task automatic t_reset;
      apb(0, A_OUT, 0); chk("output rate reset", 32'h00000000, rd);
      apb(0, A_REF, 0); chk("reference rate reset", 32'h0000000C, rd);
      apb(0, 16'h0010, 0); chk("unmapped error", 32'h00000001, {31'h0, er});
   endtask : t_reset
   task automatic t_ref;
      for (int i = 0; i < 16; i++) begin
         half_ns = 500000000.0 / hz[i];
         apb(1, A_REF, i); apb(0, A_REF, 0); chk("reference code", i, rd);
         if (hz[i] <= 4096000) begin
            repeat (8200) @(posedge pclk);
            apb(0, A_STAT, 0);
            chk("rate ok", 32'h00000001, {31'h0, rd[0]});
            chk("rate ok pin", 32'h00000001, {31'h0, ref_rate_ok});
            near("edge count", hz[i] * 2048 / 10000000, longint'(rd[31:16]), 2);
         end
      end
   endtask : t_ref
   task automatic t_out;
      for (int i = 0; i < 4; i++) begin
         apb(1, A_OUT, {i[1:0], i[1:0], 4'h0}); apb(0, A_OUT, 0); chk("output code", {i[1:0], i[1:0], 4'h0}, rd);
         repeat (10) @(posedge pclk);
         t1_n = 0; e1_n = 0;
         repeat (2000) @(posedge pclk);
         near("t1 edges", (t1f[i] > 10000000 ? 20000000 - t1f[i] : t1f[i]) / 10000, t1_n, 3);
         near("e1 edges", (e1f[i] > 10000000 ? 20000000 - e1f[i] : e1f[i]) / 10000, e1_n, 3);
      end
   endtask : t_out
   task automatic end_sim;
      $display("mismatches %0d checks %0d", err_total, checks);
      if (err_total == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      t_reset();
      t_ref();
      t_out();
      end_sim();
   end
   initial begin
      repeat (130000) @(posedge pclk);
      err_total++;
      end_sim();
   end
endmodule : master_clock_rate_select_bench
bind master_clock_rate_select clk_rate_sva chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .t1_rate_clock_out(t1_rate_clock_out), .e1_rate_clock_out(e1_rate_clock_out),
   .ref_rate_ok(ref_rate_ok));
